//--- hw/mci_pkg.sv
// Package of constants and carrier types for the motion command interface
// Behaviour
// - Reload configuration on controller run entry while idle
// - Enable low aborts the command in progress
// - Done asserts on completion of any command
// - Direction bit reported with position and speed
// - Configuration read only at power-up or reload
// - Without reload, old configuration stays in use
// - Manual function selects run or jog operation
// - Run request accelerates to requested speed, direction
// - Run release decelerates until motor stops
// - Speed may change in run; direction held
// - Short jog moves exactly the jog step distance if released before covering it
// - Long jog accelerates toward configured jog speed
// - Position is target if absolute, distance if relative
// - Go-to speed caps speed for the move
// - Mode codes 0..3: abs, rel, positive, negative
// - Speed integer, in hundredths of a pulse per clock cycle
`default_nettype none
package mci_pkg;
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned JOG_HOLD_MS = 500;
   localparam int unsigned JOG_HOLD_CYC = CLK_HZ / 1000 * JOG_HOLD_MS;
   localparam logic [31:0] ACCEL_STEP_RESET = 32'h0000_0001;
   localparam logic [31:0] PULSE_DIV_RESET = 32'h0000_0064;
   localparam logic [1:0] MODE_ABS = 2'h0;
   localparam logic [1:0] MODE_REL = 2'h1;
   localparam logic [1:0] MODE_POS = 2'h2;
   localparam logic [1:0] MODE_NEG = 2'h3;
   localparam logic [7:0] ERR_NONE = 8'h00;
   localparam logic [7:0] ERR_BUSY = 8'h01;
   localparam logic [7:0] ERR_ABORT = 8'h02;
   localparam logic [7:0] ERR_ILLEGAL = 8'h03;

   typedef enum logic [2:0] {
      MCI_IDLE, MCI_LOAD, MCI_MAN_RUN, MCI_JOG_WAIT, MCI_JOG_RUN, MCI_MOVE, MCI_STOP
   } mci_state_e;

   typedef struct packed {
      logic [31:0] jog_step_distance;
      logic [31:0] jog_speed;
      logic [31:0] accel_step;
   } mci_cfg_s;

   typedef struct packed {
      logic [31:0] position;
      logic [31:0] speed;
      logic dir;
      logic done;
      logic busy;
      logic [7:0] error;
   } mci_status_s;
endpackage : mci_pkg
`default_nettype wire

//--- hw/mci_pulse_gen.sv
// Pulse generator that steps position at a rate set by speed
`default_nettype none
module mci_pulse_gen #(
   parameter int unsigned W = 32
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [W-1:0] speed,
   input wire logic [W-1:0] divisor,
   output logic step
);
   typedef struct packed {
      logic [W-1:0] acc;
      logic step;
   } mci_pg_s;
   mci_pg_s r;
   mci_pg_s next_r;

   // Phase accumulator; one step each time it overflows the divisor
   always_comb begin
      next_r = r;
      next_r.step = 1'b0;
      if (speed != '0) begin
         if (r.acc + speed >= divisor) begin
            next_r.acc = r.acc + speed - divisor;
            next_r.step = 1'b1;
         end else begin
            next_r.acc = r.acc + speed;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign step = r.step;
endmodule : mci_pulse_gen
`default_nettype wire

//--- hw/mci_motion_top.sv
// Motion command interface: control, manual and go-to functions
`default_nettype none
module mci_motion_top #(
   parameter int unsigned JOG_HOLD_CYC = mci_pkg::JOG_HOLD_CYC
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic module_enable,
   input wire logic run_mode_entry,
   input wire logic reload_request,
   input wire mci_pkg::mci_cfg_s cfg_in,
   input wire logic output_disable_function,
   input wire logic manual_motion_function,
   input wire logic man_run,
   input wire logic man_jog_pos,
   input wire logic man_jog_neg,
   input wire logic [31:0] man_speed,
   input wire logic man_dir,
   input wire logic goto_move_function,
   input wire logic goto_start,
   input wire logic goto_abort,
   input wire logic [31:0] goto_position,
   input wire logic [31:0] goto_speed,
   input wire logic [1:0] goto_mode,
   output logic cfg_load_strobe,
   output mci_pkg::mci_status_s status,
   output logic pulse_out,
   output logic pulse_dir
);
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   typedef struct packed {
      mci_pkg::mci_state_e state;
      mci_pkg::mci_cfg_s cfg;
      logic loaded_once;
      logic run_mode_q;
      logic load_strobe;
      logic [31:0] position;
      logic [31:0] speed;
      logic [31:0] target_speed;
      logic [31:0] remaining;
      logic counted;
      logic dir;
      logic done;
      logic [7:0] error;
      logic [31:0] jog_timer;
      logic stepped;
   } mci_top_s;

   mci_top_s r;
   mci_top_s next_r;
   logic step;
   logic cmd_busy;
   logic [31:0] dist_abs;
   logic [31:0] sat_speed;

   mci_pulse_gen #(
      .W(32)
   ) u_pulse_gen (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .speed(r.speed),
      .divisor(mci_pkg::PULSE_DIV_RESET),
      .step(step)
   );

   assign cmd_busy = (r.state != mci_pkg::MCI_IDLE);

   always_comb begin
      dist_abs = '0;
      next_r = r;
      next_r.done = 1'b0;
      next_r.load_strobe = 1'b0;
      next_r.stepped = 1'b0;
      next_r.run_mode_q = run_mode_entry;
      sat_speed = r.speed + r.cfg.accel_step;
      // Position tracks every output step in the direction of dir; remaining counts down too when counted
      if (step && r.speed != '0) begin
         next_r.stepped = 1'b1;
         next_r.position = r.dir ? r.position - 32'h0000_0001 : r.position + 32'h0000_0001;
         if (r.counted && r.remaining != '0) begin
            next_r.remaining = r.remaining - 32'h0000_0001;
         end
      end
      // Ramp toward target speed, never past it
      if (r.speed < r.target_speed) begin
         next_r.speed = (sat_speed > r.target_speed) ? r.target_speed : sat_speed;
      end else if (r.speed > r.target_speed) begin
         next_r.speed = (r.speed - r.target_speed > r.cfg.accel_step) ?
            r.speed - r.cfg.accel_step : r.target_speed;
      end
      unique case (r.state)
         mci_pkg::MCI_IDLE: begin
            if (!r.loaded_once || (run_mode_entry && !r.run_mode_q) || reload_request) begin
               next_r.state = mci_pkg::MCI_LOAD;
            end else if (module_enable && !output_disable_function) begin
               if (manual_motion_function) begin
                  if (man_run) begin
                     next_r.dir = man_dir;
                     next_r.counted = 1'b0;
                     next_r.target_speed = man_speed;
                     next_r.state = mci_pkg::MCI_MAN_RUN;
                  end else if (man_jog_pos || man_jog_neg) begin
                     next_r.dir = man_jog_neg;
                     next_r.counted = 1'b1;
                     next_r.remaining = r.cfg.jog_step_distance;
                     next_r.target_speed = r.cfg.jog_speed;
                     next_r.jog_timer = '0;
                     next_r.state = mci_pkg::MCI_JOG_WAIT;
                  end
               end else if (goto_move_function && goto_start) begin
                  next_r.error = mci_pkg::ERR_NONE;
                  next_r.target_speed = goto_speed;
                  next_r.state = mci_pkg::MCI_MOVE;
                  unique case (goto_mode)
                     mci_pkg::MODE_ABS: begin
                        next_r.counted = 1'b1;
                        next_r.dir = $signed(goto_position) < $signed(r.position);
                        dist_abs = next_r.dir ? r.position - goto_position
                           : goto_position - r.position;
                        next_r.remaining = dist_abs;
                     end
                     mci_pkg::MODE_REL: begin
                        next_r.counted = 1'b1;
                        next_r.dir = goto_position[31];
                        next_r.remaining = goto_position[31] ? -goto_position : goto_position;
                     end
                     mci_pkg::MODE_POS: begin
                        next_r.counted = 1'b0;
                        next_r.dir = 1'b0;
                     end
                     mci_pkg::MODE_NEG: begin
                        next_r.counted = 1'b0;
                        next_r.dir = 1'b1;
                     end
                  endcase
                  if ((goto_mode == mci_pkg::MODE_ABS || goto_mode == mci_pkg::MODE_REL)
                     && next_r.remaining == '0) begin
                     next_r.target_speed = '0;
                     next_r.state = mci_pkg::MCI_STOP;
                  end
               end
            end
         end
         mci_pkg::MCI_LOAD: begin
            next_r.cfg = cfg_in;
            next_r.loaded_once = 1'b1;
            next_r.load_strobe = 1'b1;
            next_r.done = 1'b1;
            next_r.error = mci_pkg::ERR_NONE;
            next_r.state = mci_pkg::MCI_IDLE;
         end
         mci_pkg::MCI_MAN_RUN: begin
            next_r.target_speed = man_speed;
            if (!man_run || !manual_motion_function) begin
               next_r.target_speed = '0;
               next_r.state = mci_pkg::MCI_STOP;
            end
         end
         mci_pkg::MCI_JOG_WAIT: begin
            next_r.jog_timer = r.jog_timer + 32'h0000_0001;
            if (!(man_jog_pos || man_jog_neg)) begin
               next_r.target_speed = r.remaining == '0 ? '0 : r.cfg.jog_speed;
               next_r.state = mci_pkg::MCI_MOVE;
            end else if (r.jog_timer >= 32'(JOG_HOLD_CYC - 1)) begin
               next_r.counted = 1'b0;
               next_r.target_speed = r.cfg.jog_speed;
               next_r.state = mci_pkg::MCI_JOG_RUN;
            end else if (r.remaining == '0) begin
               next_r.target_speed = '0;
            end
         end
         mci_pkg::MCI_JOG_RUN: begin
            if (!(man_jog_pos || man_jog_neg)) begin
               next_r.target_speed = '0;
               next_r.state = mci_pkg::MCI_STOP;
            end
         end
         mci_pkg::MCI_MOVE: begin
            if (goto_abort && goto_move_function) begin
               next_r.target_speed = '0;
               next_r.counted = 1'b0;
               next_r.error = mci_pkg::ERR_ABORT;
               next_r.state = mci_pkg::MCI_STOP;
            end else if (r.counted && next_r.remaining == '0) begin
               next_r.target_speed = '0;
               next_r.speed = '0;
               next_r.state = mci_pkg::MCI_STOP;
            end
         end
         mci_pkg::MCI_STOP: begin
            if (r.speed == '0) begin
               next_r.done = 1'b1;
               next_r.state = mci_pkg::MCI_IDLE;
            end
         end
      endcase
      // Enable low or disable function aborts the command
      if ((!module_enable || output_disable_function) && cmd_busy
          && r.state != mci_pkg::MCI_LOAD) begin
         next_r.speed = '0;
         next_r.target_speed = '0;
         next_r.counted = 1'b0;
         next_r.error = mci_pkg::ERR_ABORT;
         next_r.done = 1'b1;
         next_r.state = mci_pkg::MCI_IDLE;
      end else if (cmd_busy && goto_start && goto_move_function) begin
         next_r.error = mci_pkg::ERR_BUSY;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '{state: mci_pkg::MCI_IDLE, cfg: '{'0, '0, mci_pkg::ACCEL_STEP_RESET},
                default: '0};
      end else begin
         r <= next_r;
      end
   end

   assign cfg_load_strobe = r.load_strobe;
   assign pulse_out = r.stepped;
   assign pulse_dir = r.dir;
   assign status = '{position: r.position, speed: r.speed, dir: r.dir,
                     done: r.done, busy: cmd_busy, error: r.error};
endmodule : mci_motion_top
`default_nettype wire

//--- test/mci_ctrl_model.sv
// Controller model that issues go-to commands
`default_nettype none
module mci_ctrl_model (
   input wire logic ref_clk,
   input wire logic req,
   input wire logic busy,
   input wire logic done,
   output logic start,
   output logic fn_en
);
   timeunit 1ns;
   timeprecision 100ps;
   logic req_q = 1'b0;
   initial begin
      start = 1'b0;
      fn_en = 1'b0;
   end
   always @(posedge ref_clk) begin
      req_q <= #1 req;
      start <= #1 req && !req_q;
      if (req && !req_q) begin
         fn_en <= #1 1'b1;
      end else if (done && !busy) begin
         fn_en <= #1 1'b0;
      end
   end
endmodule : mci_ctrl_model
`default_nettype wire

//--- test/mci_motion_properties.sv
// Port checker of the motion command interface
`default_nettype none
module mci_motion_properties (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic module_enable,
   input wire logic run_mode_entry,
   input wire logic reload_request,
   input wire logic output_disable_function,
   input wire logic manual_motion_function,
   input wire logic goto_move_function,
   input wire logic goto_start,
   input wire logic cfg_load_strobe,
   input wire mci_pkg::mci_status_s status,
   input wire logic pulse_out,
   input wire logic pulse_dir
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   sequence s_free;
      module_enable && !output_disable_function && goto_start && goto_move_function;
   endsequence
   sequence s_idle_start;
      s_free ##0 (!status.busy && !manual_motion_function && !reload_request
         && !$rose(run_mode_entry));
   endsequence
   property p_accept; s_idle_start |=> status.busy; endproperty
   property p_reject; s_free ##0 status.busy |=> status.error == mci_pkg::ERR_BUSY; endproperty
   property p_reload;
      $rose(run_mode_entry) && module_enable && !status.busy |-> ##[1:8] cfg_load_strobe;
   endproperty
   property p_abort; $fell(module_enable) ##0 status.busy |-> ##[1:4] !status.busy; endproperty
   property p_done;
      $fell(status.busy) && module_enable && !output_disable_function |-> ##[0:1] status.done;
   endproperty
   property p_dir;
      pulse_out |-> pulse_dir == status.dir && status.position == (status.dir ?
         $past(status.position) - 32'h0000_0001 : $past(status.position) + 32'h0000_0001);
   endproperty
   property p_step; pulse_out |-> ##[0:1] $changed(status.position); endproperty
   property p_rest; !status.busy && !$past(status.busy) |-> !pulse_out; endproperty
   a_accept: assert property (p_accept) else $error("command not taken");
   a_reject: assert property (p_reject) else $error("busy refusal missing");
   a_reload: assert property (p_reload) else $error("no reload on run entry");
   a_abort: assert property (p_abort) else $error("enable low did not abort");
   a_done: assert property (p_done) else $error("no done on completion");
   a_dir: assert property (p_dir) else $error("direction bit mismatch");
   a_step: assert property (p_step) else $error("step without position change");
   a_rest: assert property (p_rest) else $error("step while idle");
endmodule : mci_motion_properties
bind mci_motion_top mci_motion_properties i_mci_motion_properties (.ref_clk, .reset_n,
   .module_enable, .run_mode_entry, .reload_request, .output_disable_function,
   .manual_motion_function, .goto_move_function, .goto_start, .cfg_load_strobe, .status,
   .pulse_out, .pulse_dir);
`default_nettype wire

//--- test/mci_motion_top_bench.sv
// Testbench of the motion command interface
`default_nettype none
module mci_motion_top_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk, reset_n, module_enable, run_mode_entry, reload_request, output_disable_function;
   logic manual_motion_function, man_run, man_jog_pos, man_jog_neg, man_dir, req;
   logic goto_start, goto_move_function, cfg_load_strobe, pulse_out, pulse_dir;
   logic [31:0] man_speed, goto_position, goto_speed, cap;
   logic [1:0] goto_mode;
   mci_pkg::mci_cfg_s cfg_in;
   mci_pkg::mci_status_s status;
   int n_errors = 0;
   int total_checks = 0;
   int over = 0;
   int pulses = 0;
   int loads = 0;
   logic goto_abort;
   mci_motion_top #(.JOG_HOLD_CYC(20)) i_mci_motion_top (.ref_clk, .reset_n, .module_enable,
      .run_mode_entry, .reload_request, .cfg_in, .output_disable_function,
      .manual_motion_function, .man_run, .man_jog_pos, .man_jog_neg, .man_speed, .man_dir,
      .goto_move_function, .goto_start, .goto_abort, .goto_position, .goto_speed,
      .goto_mode, .cfg_load_strobe, .status, .pulse_out, .pulse_dir);
   mci_ctrl_model i_mci_ctrl_model (.ref_clk, .req, .busy(status.busy), .done(status.done),
      .start(goto_start), .fn_en(goto_move_function));
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
      total_checks++;
      if (got !== ex) begin
         n_errors++;
         $display("wrong value %s expected %0h seen %0h", nm, ex, got);
      end
   endtask : chk
   task automatic tick(int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick
   task automatic idle();
      int k;
      for (k = 0; k < 5000 && (k < 3 || status.busy !== 1'b0); k++) begin
         tick(1);
         if (status.busy === 1'b1 && status.speed > cap) over++;
         if (pulse_out === 1'b1) pulses++;
         if (cfg_load_strobe === 1'b1) loads++;
      end
      if (k == 5000) begin
         n_errors++;
         $display("wrong value busy expected 0 seen 1");
         print_verdict();
      end
   endtask : idle
   task automatic go(logic [1:0] m, logic [31:0] p, logic [31:0] s);
      goto_mode = m;
      goto_position = p;
      goto_speed = s;
      cap = s;
      pulses = 0;
      req = 1'b1;
      tick(1);
      req = 1'b0;
   endtask : go
   task automatic jog(logic neg, int n);
      man_jog_pos = !neg;
      man_jog_neg = neg;
      tick(n);
      man_jog_pos = 1'b0;
      man_jog_neg = 1'b0;
      idle();
   endtask : jog
   initial begin
      {reset_n, run_mode_entry, reload_request, output_disable_function, req, goto_abort} = '0;
      {manual_motion_function, man_run, man_jog_pos, man_jog_neg, man_dir} = '0;
      {man_speed, goto_position, goto_speed, goto_mode} = '0;
      module_enable = 1'b1;
      cap = 32'hFFFF_FFFF;
      cfg_in = '{32'h0000_0004, 32'h0000_0064, 32'h0000_000A};
      tick(16);
      reset_n = 1'b1;
      idle();
      go(mci_pkg::MODE_REL, 32'h3, 32'h64);
      idle();
      chk("rel", 32'h3, status.position);
      chk("rel pulses", 32'h3, 32'(pulses));
      go(mci_pkg::MODE_ABS, 32'hA, 32'h32);
      tick(5);
      go(mci_pkg::MODE_ABS, 32'hA, 32'h32);
      tick(3);
      chk("error", 32'(mci_pkg::ERR_BUSY), 32'(status.error));
      idle();
      chk("abs", 32'hA, status.position);
      chk("cap", 32'h0, 32'(over));
      manual_motion_function = 1'b1;
      jog(1'b0, 3);
      chk("jog pos", 32'hE, status.position);
      cfg_in.jog_step_distance = 32'h8;
      jog(1'b1, 3);
      chk("jog old cfg", 32'hA, status.position);
      loads = 0;
      reload_request = 1'b1;
      tick(1);
      reload_request = 1'b0;
      idle();
      chk("reload strobe", 32'h1, 32'(loads));
      jog(1'b0, 3);
      chk("jog new cfg", 32'h12, status.position);
      man_jog_pos = 1'b1;
      tick(40);
      chk("jog long", 32'h1, 32'(status.speed != 0));
      man_jog_pos = 1'b0;
      idle();
      loads = 0;
      run_mode_entry = 1'b1;
      idle();
      chk("run entry strobe", 32'h1, 32'(loads));
      man_speed = 32'h64;
      man_run = 1'b1;
      tick(30);
      chk("run", 32'h1, 32'(status.speed != 0));
      man_speed = 32'h32;
      tick(20);
      chk("slower", 32'h1, 32'(status.speed <= 32'h32));
      man_run = 1'b0;
      idle();
      chk("stopped", 32'h0, status.speed);
      manual_motion_function = 1'b0;
      go(mci_pkg::MODE_ABS, 32'h5, 32'h64);
      idle();
      chk("abs", 32'h5, status.position);
      go(mci_pkg::MODE_REL, 32'h100, 32'h64);
      tick(20);
      goto_abort = 1'b1;
      idle();
      goto_abort = 1'b0;
      chk("abort", 32'(mci_pkg::ERR_ABORT), 32'(status.error));
      for (int m = 2; m < 4; m++) begin
         go(2'(m), 32'h0, 32'h64);
         tick(20);
         chk("cont busy", 32'h1, 32'(status.busy));
         chk("dir", 32'(m == 3), 32'(status.dir));
         module_enable = 1'b0;
         idle();
         chk("aborted", 32'h0, 32'(status.busy));
         module_enable = 1'b1;
         tick(2);
      end
      print_verdict();
   end
endmodule : mci_motion_top_bench
`default_nettype wire
